// file: common/strap_pkg.sv
package strap_pkg;

	// strap pin positions in the shared pin vector
	localparam int STRAP_PINS      = 12;
	localparam int PIN_CONFIG_LSB  = 0;
	localparam int PIN_ADDR_LSB    = 3;
	localparam int PIN_NEG         = 6;
	localparam int PIN_SPEED       = 7;
	localparam int PIN_DUPLEX      = 8;
	localparam int PIN_TREE_N      = 9;
	localparam int PIN_FILTER      = 10;
	localparam int PIN_ADDR_ZERO   = 11;

	// weak pull direction per pin while in reset, 1 = pull-up
	localparam logic [STRAP_PINS-1:0] PULL_UP_MASK = 12'h3c8;

	// configuration strap codes
	localparam logic [2:0] CFG_NORMAL_NO_CROSS = 3'h0;
	localparam logic [2:0] CFG_NORMAL_CROSS    = 3'h2;
	localparam logic [2:0] CFG_BACK_TO_BACK    = 3'h6;

	// register byte addresses
	localparam logic [7:0] ADDR_CONTROL   = 8'h00;
	localparam logic [7:0] ADDR_ADVERTISE = 8'h04;
	localparam logic [7:0] ADDR_SETUP     = 8'h08;
	localparam logic [7:0] ADDR_STRAPS    = 8'h0c;

	// control register fields
	localparam int CTRL_SPEED  = 13;
	localparam int CTRL_NEG    = 12;
	localparam int CTRL_DUPLEX = 8;

	// advertisement register fields
	localparam int ADV_100FD = 8;
	localparam int ADV_100HD = 7;
	localparam int ADV_10FD  = 6;
	localparam int ADV_10HD  = 5;
	localparam logic [4:0] ADV_SELECTOR = 5'h01;

	// setup register field
	localparam int SETUP_FILTER_DIS = 0;

	// management address layout
	localparam logic [1:0] MGMT_ADDR_UPPER = 2'h0;

	// strap pins as captured, most significant pin first
	typedef struct packed {
		logic       addr_zero_unique;
		logic       filter_disable;
		logic       test_tree_n;
		logic       duplex;
		logic       speed;
		logic       neg_enable;
		logic [2:0] mgmt_addr;
		logic [2:0] config_code;
	} strap_field_type;

	// settings that leave the block
	typedef struct packed {
		logic       valid;
		logic       neg_enable;
		logic       speed_100;
		logic       full_duplex;
		logic       auto_crossover;
		logic       back_to_back;
		logic       config_reserved;
		logic       test_tree_enable;
		logic       filter_disable;
		logic       addr_zero_unique;
		logic [4:0] mgmt_addr;
	} link_setup_type;

endpackage : strap_pkg

// file: hdl/strap_pad_bank.sv
`timescale 1ns/100ps
module strap_pad_bank
	import strap_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [STRAP_PINS-1:0] pin_in,
	input  wire logic [STRAP_PINS-1:0] func_out,
	output logic      [STRAP_PINS-1:0] pin_out,
	output logic      [STRAP_PINS-1:0] pin_oe,
	output logic                       pull_en,
	output logic      [STRAP_PINS-1:0] pull_up,
	output strap_field_type            capture,
	output logic                       capture_pulse
);

	typedef struct packed {
		logic                  sampled;
		logic                  pulse;
		strap_field_type       capture;
		logic [STRAP_PINS-1:0] out;
		logic [STRAP_PINS-1:0] oe;
		logic                  pull_en;
	} pad_state_type;

	pad_state_type s;
	pad_state_type next_s;

	// one capture after release, then the pins become outputs
	always_comb begin
		next_s = s;
		next_s.pulse = 1'b0;
		if (!s.sampled) begin
			next_s.sampled = 1'b1;
			next_s.pulse   = 1'b1;
			next_s.capture = strap_field_type'(pin_in);
		end else begin
			next_s.out     = func_out;
			next_s.oe      = '1;
			next_s.pull_en = 1'b0;
		end
	end

	// pins float with weak pulls while in reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s         <= '0;
			s.pull_en <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign pin_out       = s.out;
	assign pin_oe        = s.oe;
	assign pull_en       = s.pull_en;
	assign pull_up       = PULL_UP_MASK;
	assign capture       = s.capture;
	assign capture_pulse = s.pulse;

	a_capture_held: assert property (@(posedge clk) disable iff (!rst_n)
		$past(s.sampled) |-> $stable(s.capture))
		else $error("strap capture changed after the first sample");

	a_pins_drive: assert property (@(posedge clk) disable iff (!rst_n)
		s.pulse |=> (s.oe == '1) && !s.pull_en)
		else $error("strap pins not turned to outputs after capture");

	a_pins_float: assert property (@(posedge clk) disable iff (!rst_n)
		!s.sampled |-> (s.oe == '0) && s.pull_en)
		else $error("strap pins driven before capture");

endmodule : strap_pad_bank

// file: hdl/strap_config_latch.sv
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module strap_config_latch
	import strap_pkg::*;
(
	input  wire logic                  SYS_CLK,
	input  wire logic                  RST_N,
	input  wire logic                  HSEL,
	input  wire logic [7:0]            HADDR,
	input  wire logic [1:0]            HTRANS,
	input  wire logic                  HWRITE,
	input  wire logic [2:0]            HSIZE,
	input  wire logic [31:0]           HWDATA,
	input  wire logic                  HREADY,
	output logic      [31:0]           HRDATA,
	output logic                       HREADYOUT,
	output logic                       HRESP,
	input  wire logic [STRAP_PINS-1:0] STRAP_PIN_IN,
	input  wire logic [STRAP_PINS-1:0] STRAP_FUNC_OUT,
	output logic      [STRAP_PINS-1:0] STRAP_PIN_OUT,
	output logic      [STRAP_PINS-1:0] STRAP_PIN_OE,
	output logic                       STRAP_PULL_EN,
	output logic      [STRAP_PINS-1:0] STRAP_PULL_UP,
	input  wire logic [4:0]            QUERY_ADDR,
	output logic                       QUERY_HIT,
	output link_setup_type             LINK_SETUP
);

	typedef struct packed {
		logic                  hready;
		logic                  wr_pend;
		logic [7:0]            wr_addr;
		logic [31:0]           rdata;
		logic                  valid;
		logic                  speed;
		logic                  neg;
		logic                  duplex;
		logic [3:0]            adv;
		logic                  filter_dis;
		strap_field_type       straps;
		logic                  hit;
		link_setup_type        setup;
	} latch_state_type;

	latch_state_type s;
	latch_state_type next_s;
	strap_field_type capture;
	logic            capture_pulse;

	// management address match, used only by the answer flag
	function automatic logic addr_match(input logic [4:0] query, input logic [2:0] own,
		input logic unique_zero);
		addr_match = (query == {MGMT_ADDR_UPPER, own}) ||
			((query == 5'h00) && !unique_zero);
	endfunction : addr_match

	// register read view of a state copy
	function automatic logic [31:0] read_word(input latch_state_type v, input logic [7:0] a);
		read_word = 32'h0000_0000;
		case (a)
			ADDR_CONTROL: begin
				read_word[CTRL_SPEED]  = v.speed;
				read_word[CTRL_NEG]    = v.neg;
				read_word[CTRL_DUPLEX] = v.duplex;
			end
			ADDR_ADVERTISE: read_word[8:0] = {v.adv, ADV_SELECTOR};
			ADDR_SETUP:     read_word[SETUP_FILTER_DIS] = v.filter_dis;
			ADDR_STRAPS:    read_word[11:0] = {v.valid, v.setup.config_reserved,
				v.straps.addr_zero_unique, !v.straps.test_tree_n,
				v.setup.mgmt_addr, v.straps.config_code};
			default:        read_word = 32'h0000_0000;
		endcase
	endfunction : read_word

	strap_pad_bank u_pads (
		.clk           (SYS_CLK),
		.rst_n         (RST_N),
		.pin_in        (STRAP_PIN_IN),
		.func_out      (STRAP_FUNC_OUT),
		.pin_out       (STRAP_PIN_OUT),
		.pin_oe        (STRAP_PIN_OE),
		.pull_en       (STRAP_PULL_EN),
		.pull_up       (STRAP_PULL_UP),
		.capture       (capture),
		.capture_pulse (capture_pulse)
	);

	// strap load, register writes, then read data and derived settings
	always_comb begin
		next_s = s;
		next_s.hready = 1'b1;
		if (capture_pulse) begin
			next_s.valid      = 1'b1;
			next_s.straps     = capture;
			next_s.neg        = capture.neg_enable;
			next_s.speed      = capture.speed;
			next_s.duplex     = !capture.duplex;
			next_s.adv        = {capture.speed, capture.speed, 2'h3};
			next_s.filter_dis = capture.filter_disable;
		end
		// write data phase; a load in the same cycle loses to software
		if (s.wr_pend) begin
			case (s.wr_addr)
				ADDR_CONTROL: begin
					next_s.speed  = HWDATA[CTRL_SPEED];
					next_s.neg    = HWDATA[CTRL_NEG];
					next_s.duplex = HWDATA[CTRL_DUPLEX];
				end
				ADDR_ADVERTISE: next_s.adv = HWDATA[ADV_100FD:ADV_10HD];
				ADDR_SETUP:     next_s.filter_dis = HWDATA[SETUP_FILTER_DIS];
				default: ;
			endcase
		end
		// address phase; read data built from the updated copy so a read
		// right behind a write already sees the new value
		next_s.wr_pend = 1'b0;
		if (HSEL && HTRANS[1] && HREADY) begin
			next_s.wr_pend = HWRITE;
			next_s.wr_addr = {HADDR[7:2], 2'h0};
			if (!HWRITE)
				next_s.rdata = read_word(next_s, {HADDR[7:2], 2'h0});
		end
		// derived settings
		next_s.setup.valid            = next_s.valid;
		next_s.setup.neg_enable       = next_s.neg;
		next_s.setup.speed_100        = next_s.speed;
		next_s.setup.full_duplex      = next_s.duplex;
		next_s.setup.auto_crossover   = (next_s.straps.config_code == CFG_NORMAL_CROSS) ||
			(next_s.straps.config_code == CFG_BACK_TO_BACK);
		next_s.setup.back_to_back     = next_s.straps.config_code == CFG_BACK_TO_BACK;
		next_s.setup.config_reserved  = !next_s.setup.auto_crossover &&
			(next_s.straps.config_code != CFG_NORMAL_NO_CROSS);
		next_s.setup.test_tree_enable = !next_s.straps.test_tree_n;
		next_s.setup.filter_disable   = next_s.filter_dis;
		next_s.setup.addr_zero_unique = next_s.straps.addr_zero_unique;
		next_s.setup.mgmt_addr        = {MGMT_ADDR_UPPER, next_s.straps.mgmt_addr};
		next_s.hit = addr_match(QUERY_ADDR, next_s.straps.mgmt_addr,
			next_s.straps.addr_zero_unique);
	end

	// defaults equal the unstrapped pin levels until the capture lands
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s                        <= '0;
			s.speed                  <= 1'b1;
			s.neg                    <= 1'b1;
			s.adv                    <= 4'hf;
			s.straps.test_tree_n     <= 1'b1;
			s.straps.duplex          <= 1'b1;
			s.straps.speed           <= 1'b1;
			s.straps.neg_enable      <= 1'b1;
			s.straps.mgmt_addr       <= 3'h1;
			s.setup.neg_enable       <= 1'b1;
			s.setup.speed_100        <= 1'b1;
			s.setup.mgmt_addr        <= 5'h01;
		end else begin
			s <= next_s;
		end
	end

	assign HRDATA     = s.rdata;
	assign HREADYOUT  = s.hready;
	assign HRESP      = 1'b0;
	assign QUERY_HIT  = s.hit;
	assign LINK_SETUP = s.setup;

	a_neg_load: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		capture_pulse && !s.wr_pend |=> s.neg == $past(capture.neg_enable))
		else $error("negotiation bit not loaded from strap");

	a_speed_load: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		capture_pulse && !s.wr_pend |=> s.speed == $past(capture.speed) &&
		s.adv[3] == $past(capture.speed) && s.adv[2] == $past(capture.speed))
		else $error("speed bits not loaded from strap");

	a_duplex_inv: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		capture_pulse && !s.wr_pend |=> s.duplex != $past(capture.duplex))
		else $error("duplex bit not inverted strap");

	a_filter_load: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		capture_pulse && !s.wr_pend |=> ##1 LINK_SETUP.filter_disable ==
		$past(capture.filter_disable, 2))
		else $error("filter setting does not follow strap");

	a_cross_decode: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		LINK_SETUP.auto_crossover == (s.straps.config_code[1:0] == 2'h2))
		else $error("crossover setting does not match configuration code");

	a_tree_level: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		LINK_SETUP.test_tree_enable != s.straps.test_tree_n)
		else $error("test tree setting has wrong polarity");

	a_addr_upper: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		LINK_SETUP.mgmt_addr[4:3] == 2'h0 &&
		LINK_SETUP.mgmt_addr[2:0] == s.straps.mgmt_addr)
		else $error("management address upper bits not zero");

	a_zero_answer: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		QUERY_ADDR == 5'h00 && !s.straps.addr_zero_unique && !capture_pulse |=> QUERY_HIT)
		else $error("broadcast address zero not answered");

	a_ahb_ready: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$past(RST_N) |-> HREADYOUT && !HRESP)
		else $error("slave stalled or answered with error");

endmodule : strap_config_latch

// file: sim/strap_board_model.sv
`timescale 1ns/100ps
module strap_board_model
	import strap_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic [STRAP_PINS-1:0] pin_out,
	input  wire logic [STRAP_PINS-1:0] pin_oe,
	input  wire logic                  pull_en,
	input  wire logic [STRAP_PINS-1:0] pull_up,
	input  wire logic                  strap_en,
	input  wire logic [STRAP_PINS-1:0] strap_val,
	output logic      [STRAP_PINS-1:0] pin_level
);
	logic [STRAP_PINS-1:0] last_level;

	// remembered so a floating pin shows the inverse, not a stale match
	always_ff @(posedge clk) begin
		last_level <= pin_level;
	end

	// device drive wins, then board resistors or mac, then weak pulls
	always_comb begin
		for (int i = 0; i < STRAP_PINS; i++) begin
			if (pin_oe[i])
				pin_level[i] = pin_out[i];
			else if (strap_en)
				pin_level[i] = strap_val[i];
			else if (pull_en)
				pin_level[i] = pull_up[i];
			else
				pin_level[i] = ~last_level[i];
		end
	end
endmodule : strap_board_model

// file: sim/tb.sv
`timescale 1ns/100ps
module tb
	import strap_pkg::*;
;
	logic                  sys_clk;
	logic                  rst_n;
	logic                  hsel;
	logic                  hwrite;
	logic [7:0]            haddr;
	logic [1:0]            htrans;
	logic [31:0]           hwdata;
	logic [31:0]           hrdata;
	logic                  hreadyout;
	logic                  hresp;
	logic [STRAP_PINS-1:0] pin_level;
	logic [STRAP_PINS-1:0] func_out;
	logic [STRAP_PINS-1:0] pin_out;
	logic [STRAP_PINS-1:0] pin_oe;
	logic [STRAP_PINS-1:0] pull_up;
	logic [STRAP_PINS-1:0] strap_val;
	logic                  pull_en;
	logic                  strap_en;
	logic                  query_hit;
	logic [4:0]            query_addr;
	link_setup_type        setup;
	int                    failures;
	int                    tests_run;
	int                    cycles = 0;
	logic [11:0]           codes [5] = '{12'h0c2, 12'hc3e, 12'h3cf, 12'h1cc, 12'h080};

	strap_config_latch strap_config_latch_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.STRAP_PIN_IN(pin_level), .STRAP_FUNC_OUT(func_out), .STRAP_PIN_OUT(pin_out),
		.STRAP_PIN_OE(pin_oe), .STRAP_PULL_EN(pull_en), .STRAP_PULL_UP(pull_up),
		.QUERY_ADDR(query_addr), .QUERY_HIT(query_hit), .LINK_SETUP(setup));

	strap_board_model strap_board_model_i (.clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pull_en(pull_en), .pull_up(pull_up), .strap_en(strap_en), .strap_val(strap_val),
		.pin_level(pin_level));

	// clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check_word

	task automatic check_setup(input string name, input link_setup_type exp,
		input link_setup_type got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check_setup

	// both tasks are entered just after a rising edge; zero wait states not assumed
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= 1'b1;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
	endtask : bus_write

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= 1'b0;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : bus_read

	// expected settings worked out from the strap levels alone
	function automatic link_setup_type exp_setup(input logic [11:0] v);
		strap_field_type f;
		link_setup_type  s;
		f = v;
		s.valid = 1'b1;
		s.neg_enable = f.neg_enable;
		s.speed_100 = f.speed;
		s.full_duplex = ~f.duplex;
		s.auto_crossover = (f.config_code == 3'h2) || (f.config_code == 3'h6);
		s.back_to_back = (f.config_code == 3'h6);
		s.config_reserved = !(f.config_code inside {3'h0, 3'h2, 3'h6});
		s.test_tree_enable = ~f.test_tree_n;
		s.filter_disable = f.filter_disable;
		s.addr_zero_unique = f.addr_zero_unique;
		s.mgmt_addr = {MGMT_ADDR_UPPER, f.mgmt_addr};
		return s;
	endfunction : exp_setup

	function automatic logic [31:0] status_word(input logic [11:0] v);
		link_setup_type s;
		s = exp_setup(v);
		return {20'h0, s.valid, s.config_reserved, s.addr_zero_unique, s.test_tree_enable,
			s.mgmt_addr, v[2:0]};
	endfunction : status_word

	task automatic query(input logic [4:0] a, input logic exp);
		query_addr <= a;
		repeat (2) @(posedge sys_clk);
		check_word("query hit", 32'(exp), 32'(query_hit));
	endtask : query

	// reset with given straps, disturb the pins after capture, then judge everything
	task automatic run_strap(input logic [11:0] v, input logic driven);
		link_setup_type s;
		logic [31:0]    d;
		logic [11:0]    w;
		w = driven ? v : PULL_UP_MASK;
		s = exp_setup(w);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		strap_en <= driven;
		strap_val <= v;
		repeat (8) @(posedge sys_clk);
		check_word("oe in reset", 32'h0, 32'(pin_oe));
		check_word("pull in reset", 32'h1, 32'(pull_en));
		rst_n <= 1'b1;
		// disturb while the pins still float, right after the single capture
		repeat (1) @(posedge sys_clk);
		strap_en <= 1'b1;
		strap_val <= ~w;
		repeat (3) @(posedge sys_clk);
		strap_en <= 1'b0;
		#1;
		check_word("oe after reset", 32'hfff, 32'(pin_oe));
		check_word("pull after reset", 32'h0, 32'(pull_en));
		check_setup("link setup", s, setup);
		@(posedge sys_clk);
		bus_read(ADDR_CONTROL, d);
		check_word("control", {18'h0, s.speed_100, s.neg_enable, 3'h0, s.full_duplex, 8'h0}, d);
		bus_read(ADDR_ADVERTISE, d);
		check_word("advertise", {23'h0, s.speed_100, s.speed_100, 2'h3, ADV_SELECTOR}, d);
		bus_read(ADDR_SETUP, d);
		check_word("setup", 32'(s.filter_disable), d);
		bus_read(ADDR_STRAPS, d);
		check_word("strap status", status_word(w), d);
		query(s.mgmt_addr, 1'b1);
		query(5'h00, (s.mgmt_addr == 5'h00) || !s.addr_zero_unique);
		query(5'h08, 1'b0);
	endtask : run_strap

	// software access after the last strap run, back to back
	task automatic reg_access;
		logic [31:0] d;
		@(posedge sys_clk);
		bus_write(ADDR_CONTROL, 32'h100);
		bus_read(ADDR_CONTROL, d);
		check_word("control rw", 32'h100, d);
		check_word("link mode", 32'h1, 32'({setup.neg_enable, setup.speed_100, setup.full_duplex}));
		bus_write(ADDR_ADVERTISE, 32'h0);
		bus_read(ADDR_ADVERTISE, d);
		check_word("advertise rw", 32'(ADV_SELECTOR), d);
		bus_write(ADDR_SETUP, 32'h1);
		bus_read(ADDR_SETUP, d);
		check_word("setup rw", 32'h1, d);
		check_word("link filter", 32'h1, 32'(setup.filter_disable));
		bus_write(ADDR_STRAPS, 32'hffffffff);
		bus_read(ADDR_STRAPS, d);
		check_word("strap status ro", status_word(12'h080), d);
		bus_read(8'h10, d);
		check_word("unmapped", 32'h0, d);
		check_word("response", 32'h0, 32'(hresp));
		func_out <= 12'h5a3;
		repeat (3) @(posedge sys_clk);
		check_word("pin drive", 32'h5a3, 32'(pin_level));
	endtask : reg_access

	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwdata = 32'h0;
		func_out = 12'h000;
		strap_en = 1'b0;
		strap_val = 12'h000;
		query_addr = 5'h00;
		failures = 0;
		tests_run = 0;
		run_strap(12'h000, 1'b0);
		foreach (codes[i])
			run_strap(codes[i], 1'b1);
		reg_access();
		report_and_stop();
	end
endmodule : tb
